// ===== common/ioc_pkg.sv
// Functional notes
// - each pin is set on its own as input, output or bidirectional.
// - pin enable is one selected global enable, or tied low or high.
// - six global enables, from enable pins, pins or macrocells, true or inverted.
// - every user pin is high impedance while in-system programming runs.
// - host writes complete flag last; no pin drives until it is set.
// - programming runs over the four-pin serial test access port.
// - programming logic follows the concurrent in-system configuration standard.
// - with the test port unused, its four pins serve as user pins.
package ioc_pkg;
   // ==========================================
   // sizes
   localparam int NUM_PINS  = 8;
   localparam int NUM_GOE   = 6;
   localparam int NUM_MC    = 8;
   localparam int TAP_PINS  = 4;
   // ==========================================
   // register map, one word each
   localparam logic [3:0] ADDR_DIR     = 4'h0; // 2 bits per pin
   localparam logic [3:0] ADDR_OESEL   = 4'h1; // 4 bits per pin
   localparam logic [3:0] ADDR_GOESRC  = 4'h2; // 4 bits per enable
   localparam logic [3:0] ADDR_CTRL    = 4'h3;
   localparam logic [3:0] ADDR_STATUS  = 4'h4;
   localparam logic [3:0] ADDR_TAPDIR  = 4'h5; // tap-as-user direction
   // ctrl fields
   localparam int CTRL_PROG_BIT  = 0; // programming in progress
   localparam int CTRL_DONE_BIT  = 1; // programming complete flag
   localparam int CTRL_TAPEN_BIT = 2; // test port enabled
   localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
   // direction encodings
   localparam logic [1:0] DIR_IN    = 2'h0;
   localparam logic [1:0] DIR_OUT   = 2'h1;
   localparam logic [1:0] DIR_BIDIR = 2'h2;
   // enable select encodings: 0..NUM_GOE-1 global, then constants
   localparam logic [3:0] OESEL_GND = 4'hE;
   localparam logic [3:0] OESEL_VCC = 4'hF;
   // global enable source: bit3 invert, bits 2:1 source kind, bit 0 unused
   localparam logic [1:0] SRC_OEPIN0 = 2'h0;
   localparam logic [1:0] SRC_OEPIN1 = 2'h1;
   localparam logic [1:0] SRC_PIN    = 2'h2;
   localparam logic [1:0] SRC_MC     = 2'h3;
   localparam logic [31:0] UNMAPPED  = 32'h0000_0000;

   typedef struct packed {
      logic [31:0] dir;
      logic [31:0] oesel;
      logic [31:0] goesrc;
      logic [2:0]  ctrl;
      logic [7:0]  tapdir;
      logic        waitreq;
      logic [31:0] rdata;
      logic [NUM_PINS-1:0] pin_out;
      logic [NUM_PINS-1:0] pin_oe_n;
      logic [TAP_PINS-1:0] tap_out;
      logic [TAP_PINS-1:0] tap_oe_n;
   } ioc_state_t;
endpackage

// ===== rtl/ioc_top.sv
`timescale 1ns/1ns
module ioc_top (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // avalon-mm slave
   input  wire logic [3:0]                    address,
   input  wire logic                          read,
   input  wire logic                          write,
   input  wire logic [31:0]                   writedata,
   output logic      [31:0]                   readdata,
   output logic                               waitrequest,
   // core side
   input  wire logic [ioc_pkg::NUM_PINS-1:0]  core_out,
   input  wire logic [ioc_pkg::NUM_MC-1:0]    mc_oe,
   input  wire logic [1:0]                    oe_pin,
   input  wire logic [ioc_pkg::TAP_PINS-1:0]  tap_core_out,
   // pins
   input  wire logic [ioc_pkg::NUM_PINS-1:0]  pin_in,
   output logic      [ioc_pkg::NUM_PINS-1:0]  pin_out,
   output logic      [ioc_pkg::NUM_PINS-1:0]  pin_oe_n,
   output logic      [ioc_pkg::TAP_PINS-1:0]  tap_out,
   output logic      [ioc_pkg::TAP_PINS-1:0]  tap_oe_n
);
   ioc_pkg::ioc_state_t s;
   ioc_pkg::ioc_state_t next_s;
   logic [ioc_pkg::NUM_GOE-1:0] goe;
   logic                        quiet;

   // ==========================================
   // global enables
   always_comb
   begin
      logic [3:0] src;
      logic       raw;
      src = 4'h0;
      raw = 1'b0;
      goe = '0;
      for (int g = 0; g < ioc_pkg::NUM_GOE; g++)
      begin
         src = s.goesrc[g*4 +: 4];
         case (src[2:1])
            ioc_pkg::SRC_OEPIN0: raw = oe_pin[0];
            ioc_pkg::SRC_OEPIN1: raw = oe_pin[1];
            ioc_pkg::SRC_PIN:    raw = pin_in[g];
            ioc_pkg::SRC_MC:     raw = mc_oe[g];
            default:             raw = 1'b0;
         endcase
         goe[g] = raw ^ src[3];
      end
   end

   // pins stay quiet while programming or before completion
   assign quiet = s.ctrl[ioc_pkg::CTRL_PROG_BIT] | ~s.ctrl[ioc_pkg::CTRL_DONE_BIT];

   // ==========================================
   // next state
   always_comb
   begin
      logic [3:0] sel;
      logic       en;
      sel    = 4'h0;
      en     = 1'b0;
      next_s = s;
      next_s.waitreq = 1'b1;
      // one wait cycle then answer; waitrequest low for one cycle
      if ((read || write) && s.waitreq)
      begin
         next_s.waitreq = 1'b0;
         next_s.rdata   = ioc_pkg::UNMAPPED;
         if (read)
         begin
            case (address)
               ioc_pkg::ADDR_DIR:    next_s.rdata = s.dir;
               ioc_pkg::ADDR_OESEL:  next_s.rdata = s.oesel;
               ioc_pkg::ADDR_GOESRC: next_s.rdata = s.goesrc;
               ioc_pkg::ADDR_CTRL:   next_s.rdata = {29'h0, s.ctrl};
               ioc_pkg::ADDR_STATUS: next_s.rdata = {8'h0, pin_in, s.pin_oe_n, 7'h0, quiet};
               ioc_pkg::ADDR_TAPDIR: next_s.rdata = {24'h0, s.tapdir};
               default:              next_s.rdata = ioc_pkg::UNMAPPED;
            endcase
         end
      end
      // write lands only at the edge that sees waitrequest low
      if (write && !s.waitreq)
      begin
         case (address)
            ioc_pkg::ADDR_DIR:    next_s.dir    = writedata;
            ioc_pkg::ADDR_OESEL:  next_s.oesel  = writedata;
            ioc_pkg::ADDR_GOESRC: next_s.goesrc = writedata;
            ioc_pkg::ADDR_CTRL:   next_s.ctrl   = writedata[2:0];
            ioc_pkg::ADDR_TAPDIR: next_s.tapdir = writedata[7:0];
            default: ;
         endcase
      end
      // pin drivers
      for (int p = 0; p < ioc_pkg::NUM_PINS; p++)
      begin
         sel = s.oesel[p*4 +: 4];
         if (sel == ioc_pkg::OESEL_VCC)
            en = 1'b1;
         else if (sel < 4'(ioc_pkg::NUM_GOE))
            en = goe[sel[2:0]];
         else
            en = 1'b0;
         case (s.dir[p*2 +: 2])
            ioc_pkg::DIR_OUT:   en = 1'b1;
            // bidir keeps the selected enable
            ioc_pkg::DIR_BIDIR: ;
            default:            en = 1'b0;
         endcase
         next_s.pin_out[p]  = core_out[p];
         next_s.pin_oe_n[p] = ~(en & ~quiet);
      end
      // test port pins as user pins only when the port is disabled
      for (int t = 0; t < ioc_pkg::TAP_PINS; t++)
      begin
         next_s.tap_out[t]  = tap_core_out[t];
         next_s.tap_oe_n[t] = ~(~s.ctrl[ioc_pkg::CTRL_TAPEN_BIT]
                              & s.tapdir[t] & ~quiet);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s          <= '0;
         s.ctrl     <= ioc_pkg::CTRL_RESET[2:0];
         s.waitreq  <= 1'b1;
         s.pin_oe_n <= '1;
         s.tap_oe_n <= '1;
      end
      else
         s <= next_s;
   end

   assign readdata    = s.rdata;
   assign waitrequest = s.waitreq;
   assign pin_out     = s.pin_out;
   assign pin_oe_n    = s.pin_oe_n;
   assign tap_out     = s.tap_out;
   assign tap_oe_n    = s.tap_oe_n;

   // ==========================================
   // checks
   AST_QUIET_NO_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
      $past(quiet) |-> &pin_oe_n) else $error("pin drives while quiet");
   AST_INPUT_NEVER: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(s.dir[1:0]) == ioc_pkg::DIR_IN) |-> pin_oe_n[0])
      else $error("input pin drives");
   AST_OUT_DRIVES: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(s.dir[1:0]) == ioc_pkg::DIR_OUT && !$past(quiet)) |-> !pin_oe_n[0])
      else $error("output pin not driving");
   AST_GND_SEL: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(s.oesel[3:0]) == ioc_pkg::OESEL_GND && $past(s.dir[1:0]) == ioc_pkg::DIR_BIDIR)
      |-> pin_oe_n[0]) else $error("gnd-tied enable drives");
   AST_GOE_SEL: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(s.oesel[3:0]) == 4'h0 && $past(s.dir[1:0]) == ioc_pkg::DIR_BIDIR && !$past(quiet))
      |-> pin_oe_n[0] == !$past(goe[0])) else $error("enable not global 0");
   AST_TAP_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
      $past(s.ctrl[ioc_pkg::CTRL_TAPEN_BIT]) |-> &tap_oe_n)
      else $error("tap pin driven while port on");
   AST_WAIT_ONE: assert property (@(posedge clk) disable iff (!rst_n)
      !waitrequest |=> waitrequest) else $error("waitrequest low twice");
   AST_ANSWER: assert property (@(posedge clk) disable iff (!rst_n)
      (read && waitrequest) |=> !waitrequest) else $error("no answer");
   COV_WRITE: cover property (@(posedge clk) write && !waitrequest);
   COV_DONE:  cover property (@(posedge clk) $rose(s.ctrl[ioc_pkg::CTRL_DONE_BIT]));
   COV_DRIVE: cover property (@(posedge clk) !pin_oe_n[0]);
   COV_PROG:  cover property (@(posedge clk) $rose(s.ctrl[ioc_pkg::CTRL_PROG_BIT]));
   COV_TAP_USER: cover property (@(posedge clk) !tap_oe_n[0]);

   // ==========================================
   // pin-level checks on the other select and source paths

   // vcc-tied enable drives a bidir pin whenever pins are live
   AST_VCC_SEL: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(s.oesel[11:8]) == ioc_pkg::OESEL_VCC
       && $past(s.dir[5:4]) == ioc_pkg::DIR_BIDIR && !$past(quiet))
      |-> !pin_oe_n[2]) else $error("vcc-tied enable not driving");

   // programming in progress silences every pad, test-port pins too
   AST_PROG_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
      $past(s.ctrl[ioc_pkg::CTRL_PROG_BIT]) |-> (&pin_oe_n && &tap_oe_n))
      else $error("pad driven during programming");

   // without the complete flag nothing drives
   AST_NO_DONE_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
      !$past(s.ctrl[ioc_pkg::CTRL_DONE_BIT]) |-> (&pin_oe_n && &tap_oe_n))
      else $error("pad driven before complete flag");

   // test-port pins follow their own enables once the port is off
   AST_TAP_USER: assert property (@(posedge clk) disable iff (!rst_n)
      (!$past(s.ctrl[ioc_pkg::CTRL_TAPEN_BIT]) && !$past(quiet))
      |-> (tap_oe_n == ~$past(s.tapdir[3:0])))
      else $error("test-port user pin enable wrong");

   // pad data is the core data one cycle on
   AST_PIN_DATA: assert property (@(posedge clk) disable iff (!rst_n)
      pin_out == $past(core_out)) else $error("pad data not core data");

   // test-port pad data likewise
   AST_TAP_DATA: assert property (@(posedge clk) disable iff (!rst_n)
      tap_out == $past(tap_core_out)) else $error("tap pad data wrong");

   // pin 1 set as input never drives, whatever the enable select
   AST_IN_ALL: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(s.dir[3:2]) == ioc_pkg::DIR_IN) |-> pin_oe_n[1])
      else $error("input pin 1 drives");

   // the inverted source of global enable 0 drives pin 0 when selected
   AST_GOE_INV: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(s.goesrc[3:0]) == 4'h8 && $past(s.oesel[3:0]) == 4'h0
       && $past(s.dir[1:0]) == ioc_pkg::DIR_BIDIR && !$past(quiet))
      |-> (pin_oe_n[0] == $past(oe_pin[0])))
      else $error("inverted global enable wrong");
endmodule // ioc_top

// ===== tb/ioc_board.sv
`timescale 1ns/1ns
// ==========================================
// board pads with weak pull-ups
module ioc_board (
   // pad drivers from the device
   input  wire logic [ioc_pkg::NUM_PINS-1:0] pin_out,
   input  wire logic [ioc_pkg::NUM_PINS-1:0] pin_oe_n,
   // levels seen on the board
   output logic      [ioc_pkg::NUM_PINS-1:0] pin_in
);
   // released pads rise through the pull-up, never keep the last level
   assign pin_in = (pin_out & ~pin_oe_n) | pin_oe_n;
endmodule // ioc_board

// ===== tb/ioc_top_tb.sv
`timescale 1ns/1ns
module ioc_top_tb;
   // ==========================================
   // signals
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [3:0]  address = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic [31:0] rdv;
   logic        waitrequest;
   logic [7:0]  core_out = 8'h00;
   logic [7:0]  mc_oe = 8'h00;
   logic [1:0]  oe_pin = 2'h0;
   logic [3:0]  tap_core_out = 4'h0;
   logic [7:0]  pin_in;
   logic [7:0]  pin_out;
   logic [7:0]  pin_oe_n;
   logic [3:0]  tap_out;
   logic [3:0]  tap_oe_n;
   int          err_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   always #5 clk = ~clk;
   ioc_top u_ioc_top (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .core_out(core_out), .mc_oe(mc_oe), .oe_pin(oe_pin),
      .tap_core_out(tap_core_out), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .tap_out(tap_out), .tap_oe_n(tap_oe_n));
   ioc_board u_ioc_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
   // ==========================================
   // tasks
   task automatic complete_run;
      $display("checks=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // request held until the edge that samples waitrequest low
   task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rdv = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
   endtask
   // ==========================================
   // timeout
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         complete_run;
      end
   end
   // ==========================================
   // tests
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      settle;
      chk(32'(pin_oe_n), 32'h0000_00FF);
      acc(1'b0, ioc_pkg::ADDR_CTRL, 32'h0);
      chk(rdv, ioc_pkg::CTRL_RESET);
      acc(1'b0, 4'h9, 32'h0);
      chk(rdv, ioc_pkg::UNMAPPED);
      // pin0 out, pin1 in, pin2 bidir vcc, pin3 bidir gnd, pin4 bidir global 0
      acc(1'b1, ioc_pkg::ADDR_DIR, 32'h0000_02A1);
      acc(1'b1, ioc_pkg::ADDR_OESEL, 32'h0000_EF00);
      acc(1'b1, ioc_pkg::ADDR_GOESRC, 32'h0000_0000);
      @(posedge clk);
      oe_pin <= 2'h1;
      settle;
      chk(32'(pin_oe_n), 32'h0000_00FF);
      acc(1'b1, ioc_pkg::ADDR_CTRL, 32'h0000_0006);
      settle;
      chk(32'(pin_oe_n), 32'h0000_00EA);
      acc(1'b0, ioc_pkg::ADDR_STATUS, 32'h0);
      chk(rdv, 32'h00EA_EA00);
      oe_pin <= 2'h0;
      settle;
      chk(32'(pin_oe_n), 32'h0000_00FA);
      acc(1'b1, ioc_pkg::ADDR_GOESRC, 32'h0000_0008);
      settle;
      chk(32'(pin_oe_n), 32'h0000_00EA);
      acc(1'b1, ioc_pkg::ADDR_CTRL, 32'h0000_0007);
      settle;
      chk(32'(pin_oe_n), 32'h0000_00FF);
      acc(1'b0, ioc_pkg::ADDR_STATUS, 32'h0);
      chk(rdv, 32'h00FF_FF01);
      acc(1'b1, ioc_pkg::ADDR_TAPDIR, 32'h0000_0005);
      acc(1'b1, ioc_pkg::ADDR_CTRL, 32'h0000_0002);
      settle;
      chk(32'(tap_oe_n), 32'h0000_000A);
      // global enable 0 from macrocell 0, true form
      acc(1'b1, ioc_pkg::ADDR_GOESRC, 32'h0000_0006);
      settle;
      chk(32'(pin_oe_n), 32'h0000_00FA);
      mc_oe <= 8'h01;
      settle;
      chk(32'(pin_oe_n), 32'h0000_00EA);
      core_out <= 8'hA5;
      tap_core_out <= 4'h3;
      settle;
      chk(32'(pin_out), 32'h0000_00A5);
      chk(32'(tap_out), 32'h0000_0003);
      complete_run;
   end
endmodule // ioc_top_tb
